// *** hw/csp_regs.svh ***
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH
// Function response status bit positions (bit 0 is the MSB of the byte)
`define CSP_ST_INT_PEND 0
`define CSP_ST_AUTO 3
`define CSP_ST_UNUSUAL 4
`define CSP_ST_UNUSED 7
// Data-in byte positions
`define CSP_DI_CASE_POS 2
`define CSP_DI_ZERO_POS 1
`define CSP_DI_LONG_POS 0
// Terminal order bit positions
`define CSP_TO_INT 0
`define CSP_TO_COUNT_DONE 1
`define CSP_TO_IOP_HALT 3
// Order-in status bit positions
`define CSP_OI_UNUSUAL 3
`define CSP_OI_CHAN_END 4
// Reset values
`define CSP_CASE_RESET 1'b0
`endif

// *** hw/csp_pkg.sv ***
package csp_pkg;
	typedef enum logic [1:0] {
		CSP_SVC_DATA_IN = 2'b00,
		CSP_SVC_DATA_OUT = 2'b01,
		CSP_SVC_ORDER_IN = 2'b10,
		CSP_SVC_ORDER_OUT = 2'b11
	} csp_svc_e;
	typedef struct packed {
		logic start;
		logic halt;
		logic test;
		logic test_dev;
		logic int_ack;
		logic [3:0] addr;
	} csp_instr_s;
	typedef struct packed {
		logic [7:0] char_bits;
		logic [5:0] line;
		logic long_space;
		logic [3:0] char_len;
		logic five_bit;
		logic is_figs;
		logic is_ltrs;
	} csp_rx_s;
	typedef struct packed {
		logic cc_first;
		logic cc_second;
		logic [7:0] func_resp;
		logic valid;
	} csp_resp_s;
endpackage

// *** hw/csp_channel_subcontroller_port.sv ***
// Operation
// - Addressed start when ready: busy, service call
// - Start while busy: status only
// - Halt clears busy and interrupts, returns ready
// - Test returns status, changes nothing
// - Test-device: both codes, zero status
// - Interrupt ack with priority: address, both codes
// - Interrupt ack clears internal interrupt indicator
// - Internal interrupt only by terminal order
// - Connect on acknowledge only with priority
// - Service type encoding; never data-out
// - First cycle order-out; order discarded
// - Character done: data-in, char then line
// - Lsb at bit seven; short chars one-filled
// - Five-bit case-shift bit at position two
// - Case bit reset-cleared, changes after passing
// - Second byte bit one always zero
// - Long-space flag in second byte
// - Order-in only after count-done or halt order
// - Order-in drives unusual end, channel end
// - Terminal order bit zero sets interrupt
// - Start/halt/test status byte layout
// - Condition code meanings per instruction
`timescale 1ns/1ps
`include "csp_regs.svh"
module csp_channel_subcontroller_port #(
	parameter logic [3:0] MY_ADDR = 4'h0
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic io_reset_i,
	input wire csp_pkg::csp_instr_s instr_i,
	input wire logic int_priority_i,
	input wire logic service_call_ack_i,
	input wire logic svc_priority_i,
	input wire logic cycle_done_i,
	input wire logic order_valid_i,
	input wire logic [7:0] order_i,
	input wire logic rx_valid_i,
	input wire csp_pkg::csp_rx_s rx_i,
	output logic rx_ready_o,
	output csp_pkg::csp_resp_s resp_o,
	output logic service_call_o,
	output logic connected_o,
	output logic data_order_request_o,
	output logic in_out_request_o,
	output logic [7:0] data_o,
	output logic data_valid_o,
	output logic ext_rx_int_o,
	output logic interrupt_ack_indicator_o
);
	typedef enum logic [2:0] {
		CSP_READY,
		CSP_WAIT_OO,
		CSP_IDLE_BUSY,
		CSP_WAIT_DI,
		CSP_BYTE2,
		CSP_WAIT_OI
	} csp_state_e;

	// --------------------------------
	// State
	// --------------------------------
	csp_state_e state_q, state_d;
	logic busy_q, busy_d;
	logic int_q, int_d;
	logic ext_q, ext_d;
	logic unusual_q, unusual_d;
	logic oi_pend_q, oi_pend_d;
	logic case_q, case_d;
	logic case_upd_q, case_upd_d;
	logic case_new_q, case_new_d;
	logic svc_q, svc_d;
	logic conn_q, conn_d;
	csp_pkg::csp_svc_e svc_type_q, svc_type_d;
	logic [7:0] data_q, data_d;
	logic dval_q, dval_d;
	logic [7:0] byte2_q, byte2_d;
	logic rx_ready_q, rx_ready_d;
	csp_pkg::csp_resp_s resp_q, resp_d;

	logic addressed;
	logic [7:0] status;
	logic [7:0] first_byte;
	logic [7:0] fill_mask;
	integer i;

	assign addressed = (instr_i.addr == MY_ADDR);

	always_comb begin
		// Status byte, bit 0 is the MSB line
		status = 8'h00;
		status[7 - `CSP_ST_INT_PEND] = int_q;
		status[7 - `CSP_ST_AUTO] = 1'b1;
		status[7 - `CSP_ST_UNUSUAL] = unusual_q;
		status[7 - 1] = busy_q;
		status[7 - 2] = busy_q;
		status[7 - 5] = busy_q;
		status[7 - 6] = busy_q;
		status[7 - `CSP_ST_UNUSED] = 1'b0;
		// Character, lsb at bit seven means lsb in the low bit here
		fill_mask = 8'h00;
		for (i = 0; i < 8; i++) begin
			if (i >= int'(rx_i.char_len)) begin
				fill_mask[i] = 1'b1;
			end
		end
		first_byte = rx_i.char_bits | fill_mask;
		if (rx_i.five_bit) begin
			first_byte[7 - `CSP_DI_CASE_POS] = case_q;
		end
	end

	always_comb begin
		state_d = state_q;
		busy_d = busy_q;
		int_d = int_q;
		ext_d = ext_q;
		unusual_d = unusual_q;
		oi_pend_d = oi_pend_q;
		case_d = case_q;
		case_upd_d = case_upd_q;
		case_new_d = case_new_q;
		svc_d = svc_q;
		conn_d = conn_q;
		svc_type_d = svc_type_q;
		data_d = data_q;
		dval_d = 1'b0;
		byte2_d = byte2_q;
		rx_ready_d = 1'b0;
		resp_d = '0;
		// Channel instructions
		if (addressed && instr_i.start) begin
			resp_d.valid = 1'b1;
			resp_d.cc_first = 1'b1;
			resp_d.cc_second = !busy_q;
			resp_d.func_resp = status;
			if (!busy_q) begin
				busy_d = 1'b1;
				svc_d = 1'b1;
				svc_type_d = csp_pkg::CSP_SVC_ORDER_OUT;
				state_d = CSP_WAIT_OO;
			end
		end else if (addressed && instr_i.halt) begin
			resp_d.valid = 1'b1;
			resp_d.cc_first = 1'b1;
			resp_d.cc_second = !busy_q;
			resp_d.func_resp = status;
		end else if (addressed && instr_i.test) begin
			resp_d.valid = 1'b1;
			resp_d.cc_first = 1'b1;
			resp_d.cc_second = !busy_q;
			resp_d.func_resp = status;
		end else if (addressed && instr_i.test_dev) begin
			resp_d.valid = 1'b1;
			resp_d.cc_first = 1'b1;
			resp_d.cc_second = 1'b1;
			resp_d.func_resp = 8'h00;
		end else if (instr_i.int_ack) begin
			if (int_q && int_priority_i) begin
				resp_d.valid = 1'b1;
				resp_d.cc_first = 1'b1;
				resp_d.cc_second = 1'b1;
				resp_d.func_resp = {4'h0, MY_ADDR};
			end
			int_d = 1'b0;
		end
		// Service cycles
		if (service_call_ack_i && svc_q && svc_priority_i && !conn_q) begin
			conn_d = 1'b1;
		end
		case (state_q)
			CSP_READY: begin
			end
			CSP_WAIT_OO: begin
				// Order delivered here is discarded
				if (conn_q && cycle_done_i) begin
					svc_d = 1'b0;
					conn_d = 1'b0;
					state_d = CSP_IDLE_BUSY;
				end
			end
			CSP_IDLE_BUSY: begin
				if (oi_pend_q) begin
					svc_d = 1'b1;
					svc_type_d = csp_pkg::CSP_SVC_ORDER_IN;
					state_d = CSP_WAIT_OI;
				end else if (rx_valid_i) begin
					rx_ready_d = 1'b1;
					svc_d = 1'b1;
					svc_type_d = csp_pkg::CSP_SVC_DATA_IN;
					data_d = first_byte;
					byte2_d = {rx_i.long_space, 1'b0, rx_i.line};
					case_upd_d = rx_i.five_bit && (rx_i.is_figs || rx_i.is_ltrs);
					case_new_d = rx_i.is_figs;
					state_d = CSP_WAIT_DI;
				end
			end
			CSP_WAIT_DI: begin
				if (conn_q) begin
					dval_d = 1'b1;
					state_d = CSP_BYTE2;
				end
			end
			CSP_BYTE2: begin
				data_d = byte2_q;
				dval_d = 1'b1;
				if (cycle_done_i) begin
					svc_d = 1'b0;
					conn_d = 1'b0;
					dval_d = 1'b0;
					if (case_upd_q) begin
						case_d = case_new_q;
					end
					state_d = CSP_IDLE_BUSY;
				end
			end
			CSP_WAIT_OI: begin
				if (conn_q) begin
					data_d = 8'h00;
					data_d[7 - `CSP_OI_UNUSUAL] = unusual_q;
					data_d[7 - `CSP_OI_CHAN_END] = 1'b1;
					dval_d = 1'b1;
					if (cycle_done_i) begin
						svc_d = 1'b0;
						conn_d = 1'b0;
						dval_d = 1'b0;
						oi_pend_d = 1'b0;
						state_d = CSP_IDLE_BUSY;
					end
				end
			end
			default: state_d = CSP_READY;
		endcase
		// Terminal orders accompany any service cycle except the first order-out
		if (conn_q && order_valid_i && state_q != CSP_WAIT_OO) begin
			if (order_i[7 - `CSP_TO_INT]) begin
				int_d = 1'b1;
			end
			if (order_i[7 - `CSP_TO_COUNT_DONE] || order_i[7 - `CSP_TO_IOP_HALT]) begin
				unusual_d = 1'b1;
				oi_pend_d = 1'b1;
			end
		end
		if (conn_q && order_valid_i && state_q == CSP_WAIT_OI) begin
			oi_pend_d = 1'b0;
		end
		if (state_q == CSP_WAIT_DI && conn_q) begin
			ext_d = 1'b1;
		end
		// Halt outranks any service cycle in flight
		if (addressed && instr_i.halt) begin
			busy_d = 1'b0;
			int_d = 1'b0;
			ext_d = 1'b0;
			svc_d = 1'b0;
			conn_d = 1'b0;
			oi_pend_d = 1'b0;
			dval_d = 1'b0;
			rx_ready_d = 1'b0;
			state_d = CSP_READY;
		end
		if (io_reset_i) begin
			case_d = `CSP_CASE_RESET;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			state_q <= CSP_READY;
			busy_q <= 1'b0;
			int_q <= 1'b0;
			ext_q <= 1'b0;
			unusual_q <= 1'b0;
			oi_pend_q <= 1'b0;
			case_q <= `CSP_CASE_RESET;
			case_upd_q <= 1'b0;
			case_new_q <= 1'b0;
			svc_q <= 1'b0;
			conn_q <= 1'b0;
			svc_type_q <= csp_pkg::CSP_SVC_ORDER_OUT;
			data_q <= 8'h00;
			dval_q <= 1'b0;
			byte2_q <= 8'h00;
			rx_ready_q <= 1'b0;
			resp_q <= '0;
		end else begin
			state_q <= state_d;
			busy_q <= busy_d;
			int_q <= int_d;
			ext_q <= ext_d;
			unusual_q <= unusual_d;
			oi_pend_q <= oi_pend_d;
			case_q <= case_d;
			case_upd_q <= case_upd_d;
			case_new_q <= case_new_d;
			svc_q <= svc_d;
			conn_q <= conn_d;
			svc_type_q <= svc_type_d;
			data_q <= data_d;
			dval_q <= dval_d;
			byte2_q <= byte2_d;
			rx_ready_q <= rx_ready_d;
			resp_q <= resp_d;
		end
	end

	// Never data-out: only three encodings are ever loaded
	assign service_call_o = svc_q;
	assign connected_o = conn_q;
	assign data_order_request_o = svc_type_q[1];
	assign in_out_request_o = svc_type_q[0];
	assign data_o = data_q;
	assign data_valid_o = dval_q;
	assign rx_ready_o = rx_ready_q;
	assign resp_o = resp_q;
	assign ext_rx_int_o = ext_q;
	assign interrupt_ack_indicator_o = int_q;
endmodule

// *** verif/csp_checker.sv ***
`timescale 1ns/1ps
module csp_checker #(
	parameter logic [3:0] MY_ADDR = 4'h0
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire csp_pkg::csp_instr_s instr_i,
	input wire logic int_priority_i,
	input wire logic service_call_ack_i,
	input wire logic svc_priority_i,
	input wire logic cycle_done_i,
	input wire logic order_valid_i,
	input wire logic [7:0] order_i,
	input wire csp_pkg::csp_resp_s resp_o,
	input wire logic service_call_o,
	input wire logic connected_o,
	input wire logic data_order_request_o,
	input wire logic in_out_request_o,
	input wire logic interrupt_ack_indicator_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	logic hit;
	logic ssh;
	logic ind;
	logic [7:0] fr;
	assign hit = instr_i.addr == MY_ADDR;
	assign ssh = (instr_i.start || instr_i.halt || instr_i.test) && hit;
	assign ind = interrupt_ack_indicator_o;
	assign fr = resp_o.func_resp;
	property p_type;
		!(!data_order_request_o && in_out_request_o);
	endproperty
	a_type: assert property (p_type) else $error("data-out asked");
	property p_stat;
		ssh |=> resp_o.valid && resp_o.cc_first && fr[4] && !fr[0] && fr[6:5] == fr[2:1]
			&& fr[6] == fr[5];
	endproperty
	a_stat: assert property (p_stat) else $error("bad status");
	property p_tdv;
		instr_i.test_dev && hit |=> resp_o.valid && resp_o.cc_first && resp_o.cc_second && fr == 8'h00;
	endproperty
	a_tdv: assert property (p_tdv) else $error("bad test device");
	property p_oo;
		instr_i.start && hit ##1 resp_o.cc_second |-> data_order_request_o && in_out_request_o;
	endproperty
	a_oo: assert property (p_oo) else $error("first not order-out");
	property p_conn;
		$rose(connected_o) |-> $past(service_call_ack_i && svc_priority_i);
	endproperty
	a_conn: assert property (p_conn) else $error("bad connect");
	property p_isrc;
		$rose(ind) |-> $past(order_valid_i && order_i[7]);
	endproperty
	a_isrc: assert property (p_isrc) else $error("stray interrupt");
	property p_drop;
		connected_o && cycle_done_i |=> !service_call_o;
	endproperty
	a_drop: assert property (p_drop) else $error("call kept");
	property p_ack;
		instr_i.int_ack && ind && int_priority_i |=> resp_o.valid && resp_o.cc_first && resp_o.cc_second
			&& fr == {4'h0, MY_ADDR};
	endproperty
	a_ack: assert property (p_ack) else $error("bad int ack");
	c_cyc: cover property (connected_o && cycle_done_i);
	c_int: cover property ($rose(ind));
	c_busy: cover property (resp_o.valid && !resp_o.cc_second);
endmodule
bind csp_channel_subcontroller_port csp_checker #(.MY_ADDR(MY_ADDR)) chk_u (
	.clock_i(clock_i),
	.rst_b_i(rst_b_i),
	.instr_i(instr_i),
	.int_priority_i(int_priority_i),
	.service_call_ack_i(service_call_ack_i),
	.svc_priority_i(svc_priority_i),
	.cycle_done_i(cycle_done_i),
	.order_valid_i(order_valid_i),
	.order_i(order_i),
	.resp_o(resp_o),
	.service_call_o(service_call_o),
	.connected_o(connected_o),
	.data_order_request_o(data_order_request_o),
	.in_out_request_o(in_out_request_o),
	.interrupt_ack_indicator_o(interrupt_ack_indicator_o)
);

// *** verif/csp_iop_model.sv ***
`timescale 1ns/1ps
module csp_iop_model (
	input wire logic clock_i,
	input wire logic svc_i,
	input wire logic conn_i,
	input wire logic [3:0] dly_i,
	input wire logic [7:0] term_i,
	output logic ack_o,
	output logic done_o,
	output logic [7:0] order_o
);
	// ----
	// Ack a call, close with a terminal order
	// ----
	initial begin
		ack_o = 1'b0;
		done_o = 1'b0;
		order_o = 8'h00;
		forever begin
			@(negedge clock_i);
			if (svc_i && !conn_i) begin
				repeat (dly_i) @(negedge clock_i);
				ack_o = 1'b1;
				@(negedge clock_i);
				ack_o = 1'b0;
				repeat (3) @(negedge clock_i);
				if (conn_i) begin
					order_o = term_i;
					done_o = 1'b1;
					@(negedge clock_i);
					done_o = 1'b0;
					order_o = ~term_i;
				end
			end
		end
	end
endmodule

// *** verif/tb_channel_subcontroller_port.sv ***
`timescale 1ns/1ps
module tb_channel_subcontroller_port;
	logic clock_i, rst_b_i, io_reset_i, int_pri, svc_pri, rx_valid, ack, done, dv_q;
	logic rx_ready_o, service_call_o, connected_o, data_order_request, in_out_request, data_valid_o, ext_int, ind;
	logic [7:0] order, term, b1, b2, data_o;
	logic [3:0] dly;
	logic [1:0] ty;
	int errors, checked;
	csp_pkg::csp_instr_s instr;
	csp_pkg::csp_rx_s rx;
	csp_pkg::csp_resp_s r, resp_o;
	csp_channel_subcontroller_port #(.MY_ADDR(4'h5)) dut_u (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.io_reset_i(io_reset_i),
		.instr_i(instr),
		.int_priority_i(int_pri),
		.service_call_ack_i(ack),
		.svc_priority_i(svc_pri),
		.cycle_done_i(done),
		.order_valid_i(done),
		.order_i(order),
		.rx_valid_i(rx_valid),
		.rx_i(rx),
		.rx_ready_o(rx_ready_o),
		.resp_o(resp_o),
		.service_call_o(service_call_o),
		.connected_o(connected_o),
		.data_order_request_o(data_order_request),
		.in_out_request_o(in_out_request),
		.data_o(data_o),
		.data_valid_o(data_valid_o),
		.ext_rx_int_o(ext_int),
		.interrupt_ack_indicator_o(ind)
	);
	csp_iop_model iop_u (
		.clock_i(clock_i),
		.svc_i(service_call_o),
		.conn_i(connected_o),
		.dly_i(dly),
		.term_i(term),
		.ack_o(ack),
		.done_o(done),
		.order_o(order)
	);
	// ----
	// Helpers
	// ----
	always @(posedge clock_i) begin
		dv_q <= data_valid_o;
		if (data_valid_o && !dv_q) begin
			b1 <= data_o;
		end else if (data_valid_o) begin
			b2 <= data_o;
		end
	end
	task automatic chk(input logic [17:0] g, input logic [17:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic ins(input logic [4:0] k, input logic [3:0] a);
		instr = {k, a};
		@(negedge clock_i);
		instr = '0;
		r = resp_o;
		@(negedge clock_i);
	endtask
	task automatic cyc();
		for (int i = 0; i < 40 && !service_call_o; i++) @(negedge clock_i);
		ty = {data_order_request, in_out_request};
		for (int i = 0; i < 40 && !done; i++) @(posedge clock_i);
		@(negedge clock_i);
	endtask
	task automatic rxc(input csp_pkg::csp_rx_s d, input logic [7:0] t, e1, e2);
		term = t;
		rx = d;
		rx_valid = 1'b1;
		for (int i = 0; i < 40 && !rx_ready_o; i++) @(negedge clock_i);
		rx_valid = 1'b0;
		rx = csp_pkg::csp_rx_s'(~d);
		cyc();
		chk({ty, b1, b2}, {2'b00, e1, e2});
	endtask
	task automatic report_and_stop();
		if (errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_idle();
		ins(5'h04, 4'h5);
		chk(r, 16'h0621);
		ins(5'h02, 4'h5);
		chk(r, 16'h0601);
		ins(5'h10, 4'h3);
		chk({r.valid, service_call_o}, 2'b00);
	endtask
	task automatic t_start();
		ins(5'h10, 4'h5);
		chk({r.valid, r.cc_first, r.cc_second, service_call_o, data_order_request, in_out_request}, 6'h3f);
		ins(5'h04, 4'h5);
		chk(r, 16'h04ed);
		ins(5'h10, 4'h5);
		chk(r, 16'h04ed);
		cyc();
		repeat (4) @(negedge clock_i);
		chk({ty, service_call_o, ind}, 4'hc);
		dly = 4'h0;
	endtask
	task automatic t_rx();
		rxc('{8'h15, 6'h2a, 1'b0, 4'h5, 1'b1, 1'b1, 1'b0}, 8'h80, 8'hd5, 8'h2a);
		chk({ind, ext_int}, 2'b11);
		ins(5'h04, 4'h5);
		chk(r, 16'h05ed);
		int_pri = 1'b1;
		ins(5'h01, 4'h0);
		chk({r.valid, r.cc_first, r.cc_second, ind}, 4'he);
		chk(r.func_resp, 8'h05);
		rxc('{8'h03, 6'h01, 1'b1, 4'h5, 1'b1, 1'b0, 1'b0}, 8'h40, 8'he3, 8'h81);
		term = 8'h80;
		cyc();
		chk({ty, b1, ind}, {2'b10, 8'h18, 1'b1});
	endtask
	task automatic t_halt();
		ins(5'h08, 4'h5);
		chk({r.valid, r.cc_first, r.cc_second, ind, ext_int}, 5'h18);
		ins(5'h04, 4'h5);
		chk({r.valid, r.cc_first, r.cc_second, r.func_resp & 8'he6}, 11'h700);
		io_reset_i = 1'b1;
		@(negedge clock_i);
		io_reset_i = 1'b0;
		svc_pri = 1'b0;
		ins(5'h10, 4'h5);
		repeat (12) @(negedge clock_i);
		chk(connected_o, 1'b0);
		svc_pri = 1'b1;
		cyc();
		rxc('{8'h03, 6'h3f, 1'b0, 4'h5, 1'b1, 1'b0, 1'b0}, 8'h00, 8'hc3, 8'h3f);
	endtask
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		repeat (3000) @(posedge clock_i);
		errors++;
		report_and_stop();
	end
	initial begin
		rst_b_i = 1'b0;
		io_reset_i = 1'b0;
		instr = '0;
		int_pri = 1'b0;
		svc_pri = 1'b1;
		rx_valid = 1'b0;
		rx = '0;
		term = 8'h80;
		dly = 4'h6;
		errors = 0;
		checked = 0;
		repeat (2) @(negedge clock_i);
		rst_b_i = 1'b1;
		t_idle();
		t_start();
		t_rx();
		t_halt();
		report_and_stop();
	end
endmodule
